// *** hw/rpg_cfg.svh ***
// register offsets, field positions and reset values of the pin configuration block
`ifndef RPG_CFG_SVH
`define RPG_CFG_SVH
`define RPG_ADDR_PIN_ENABLE 8'h44
`define RPG_ADDR_PIN_OUTPUT 8'h45
`define RPG_ADDR_PIN_INPUT 8'h46
`define RPG_ADDR_SIG_CONFIG 8'h47
`define RPG_PIN_SIG_INPUT 7
`define RPG_PIN_CLOCK_OUT 6
`define RPG_PIN_SELECT_HI 5
`define RPG_PIN_SELECT_LO 4
`define RPG_SCAN_PIN_MSB 3
`define RPG_FAST_PAD_BIT 7
`define RPG_SEL_MSB 3
`define RPG_RST_PIN_ENABLE 8'h00
`define RPG_RST_PIN_OUTPUT 8'h00
`define RPG_RST_SIG_CONFIG 8'h00
`define RPG_SEL_TRISTATE_A 4'h0
`define RPG_SEL_TRISTATE_B 4'h1
`define RPG_SEL_LOW 4'h2
`define RPG_SEL_HIGH 4'h3
`define RPG_SEL_TX_ENV 4'h4
`define RPG_SEL_TX_ACTIVE 4'h5
`define RPG_SEL_SECURE 4'h6
`define RPG_SEL_RX_ENV 4'h7
`define RPG_SEL_RX_ACTIVE 4'h8
`define RPG_SEL_RX_BIT 4'h9
`endif

// *** hw/rpg_pkg.sv ***
// types shared by the pin configuration block
package rpg_pkg;
    typedef struct packed {
        logic [7:0] addr;
        logic [7:0] wdata;
        logic wr;
        logic rd;
    } rpg_bus_req_t;

    typedef struct packed {
        logic tx_envelope;
        logic tx_active;
        logic generic_secure_module_signal;
        logic rx_envelope;
        logic rx_active;
        logic rx_bit;
    } rpg_probe_t;

    typedef struct packed {
        logic [7:0] out;
        logic [7:0] oe;
    } rpg_pad_drive_t;
endpackage

// *** hw/rpg_sync.sv ***
// three-stage synchroniser with agreement filter for one pad input
`timescale 1ns/1ns
module rpg_sync (
    input wire logic i_sys_clk,
    input wire logic i_rst_n,
    input wire logic i_async,
    output logic o_level
);
    typedef struct packed {
        logic s1;
        logic s2;
        logic s3;
        logic level;
    } rpg_sync_state_t;

    rpg_sync_state_t st;
    rpg_sync_state_t next_st;

    always_comb begin
        next_st = st;
        next_st.s1 = i_async;
        next_st.s2 = st.s1;
        next_st.s3 = st.s2;
        // a change counts only once the last two stages agree
        if (st.s2 == st.s3) begin
            next_st.level = st.s3;
        end
    end

    always_ff @(posedge i_sys_clk) begin
        if (!i_rst_n) begin
            st <= '0;
        end else begin
            st <= next_st;
        end
    end

    assign o_level = st.level;
endmodule

// *** hw/rpg_sigmux.sv ***
// source selector for the signal-output pin
`timescale 1ns/1ns
`include "rpg_cfg.svh"
module rpg_sigmux (
    input wire logic [3:0] i_sel,
    input wire rpg_pkg::rpg_probe_t i_probe,
    output logic o_value,
    output logic o_drive
);
    import rpg_pkg::*;

    always_comb begin
        o_value = 1'b0;
        o_drive = 1'b1;
        case (i_sel)
            `RPG_SEL_TRISTATE_A, `RPG_SEL_TRISTATE_B: begin
                o_drive = 1'b0;
            end
            `RPG_SEL_LOW: begin
                o_value = 1'b0;
            end
            `RPG_SEL_HIGH: begin
                o_value = 1'b1;
            end
            `RPG_SEL_TX_ENV: begin
                o_value = i_probe.tx_envelope;
            end
            `RPG_SEL_TX_ACTIVE: begin
                o_value = i_probe.tx_active;
            end
            `RPG_SEL_SECURE: begin
                o_value = i_probe.generic_secure_module_signal;
            end
            `RPG_SEL_RX_ENV: begin
                o_value = i_probe.rx_envelope;
            end
            `RPG_SEL_RX_ACTIVE: begin
                o_value = i_probe.rx_active;
            end
            `RPG_SEL_RX_BIT: begin
                o_value = i_probe.rx_bit;
            end
            default: begin
                o_drive = 1'b0;
            end
        endcase
    end
endmodule

// *** hw/rpg_top.sv ***
// general purpose pin and signal-output configuration block
//
// Added by the designer: the strobed register port.
`timescale 1ns/1ns
`include "rpg_cfg.svh"
module rpg_top (
    input wire logic i_sys_clk,
    input wire logic i_rst_n,
    input wire rpg_pkg::rpg_bus_req_t i_bus,
    output logic [7:0] o_rdata,
    input wire logic [7:0] i_pad_in,
    output rpg_pkg::rpg_pad_drive_t o_pad,
    input wire logic i_scan_mode,
    input wire logic i_device_clock,
    input wire rpg_pkg::rpg_probe_t i_probe,
    output logic o_signal_output_pin,
    output logic o_signal_output_oe,
    output logic o_fast_pad_switching
);
    import rpg_pkg::*;

    typedef struct packed {
        logic [7:0] pin_output_enable;
        logic [7:0] pin_output_value;
        logic fast_pad_switching;
        logic [3:0] signal_output_source_select;
        logic [7:0] rdata;
        rpg_pad_drive_t pad;
        logic sig_out;
        logic sig_oe;
    } rpg_state_t;

    rpg_state_t st;
    rpg_state_t next_st;
    logic [7:0] pin_level;
    logic mux_value;
    logic mux_drive;

    // ==========================================================
    // pad input synchronisers
    genvar gi;
    generate
        for (gi = 0; gi < 8; gi++) begin : g_sync
            rpg_sync u_sync (
                .i_sys_clk(i_sys_clk),
                .i_rst_n(i_rst_n),
                .i_async(i_pad_in[gi]),
                .o_level(pin_level[gi])
            );
        end
    endgenerate

    // ==========================================================
    // signal-output source selection
    rpg_sigmux u_mux (
        .i_sel(st.signal_output_source_select),
        .i_probe(i_probe),
        .o_value(mux_value),
        .o_drive(mux_drive)
    );

    // ==========================================================
    // registers and pad drive
    always_comb begin
        logic [7:0] en;
        en = st.pin_output_enable;
        next_st = st;
        next_st.rdata = 8'h00;
        if (i_bus.wr) begin
            case (i_bus.addr)
                `RPG_ADDR_PIN_ENABLE: begin
                    next_st.pin_output_enable = i_bus.wdata;
                end
                `RPG_ADDR_PIN_OUTPUT: begin
                    next_st.pin_output_value = i_bus.wdata;
                end
                `RPG_ADDR_SIG_CONFIG: begin
                    next_st.fast_pad_switching = i_bus.wdata[`RPG_FAST_PAD_BIT];
                    next_st.signal_output_source_select = i_bus.wdata[`RPG_SEL_MSB:0];
                end
                default: begin
                end
            endcase
        end
        if (i_bus.rd) begin
            case (i_bus.addr)
                `RPG_ADDR_PIN_ENABLE: begin
                    next_st.rdata = st.pin_output_enable;
                end
                `RPG_ADDR_PIN_OUTPUT: begin
                    next_st.rdata = st.pin_output_value;
                end
                `RPG_ADDR_PIN_INPUT: begin
                    // pad level regardless of enable, so driven values read back
                    next_st.rdata = pin_level;
                end
                `RPG_ADDR_SIG_CONFIG: begin
                    next_st.rdata = {st.fast_pad_switching, 3'h0,
                                     st.signal_output_source_select};
                end
                default: begin
                    next_st.rdata = 8'h00;
                end
            endcase
        end
        // scan pins stay in their scan role while scan is strapped on
        if (i_scan_mode) begin
            en[`RPG_SCAN_PIN_MSB:0] = 4'h0;
        end
        next_st.pad.oe = en;
        next_st.pad.out = st.pin_output_value;
        // without the enable the pin carries the device clock
        if (!en[`RPG_PIN_CLOCK_OUT]) begin
            next_st.pad.oe[`RPG_PIN_CLOCK_OUT] = 1'b1;
            next_st.pad.out[`RPG_PIN_CLOCK_OUT] = i_device_clock;
        end
        next_st.sig_out = mux_value;
        next_st.sig_oe = mux_drive;
    end

    always_ff @(posedge i_sys_clk) begin
        if (!i_rst_n) begin
            st <= '0;
            st.pin_output_enable <= `RPG_RST_PIN_ENABLE;
            st.pin_output_value <= `RPG_RST_PIN_OUTPUT;
        end else begin
            st <= next_st;
        end
    end

    assign o_rdata = st.rdata;
    assign o_pad = st.pad;
    assign o_signal_output_pin = st.sig_out;
    assign o_signal_output_oe = st.sig_oe;
    assign o_fast_pad_switching = st.fast_pad_switching;

    // ==========================================================
    // checks
    sequence s_sel_write(logic [3:0] v);
        i_bus.wr && i_bus.addr == `RPG_ADDR_SIG_CONFIG && i_bus.wdata[3:0] == v;
    endsequence

    a_enable_drives_oe: assert property (@(posedge i_sys_clk) disable iff (!i_rst_n)
        (i_bus.wr && i_bus.addr == `RPG_ADDR_PIN_ENABLE && !i_scan_mode) ##1 !i_scan_mode
        |=> o_pad.oe[7] == $past(i_bus.wdata[7], 2))
        else $error("pin enable not applied");
    a_clock_out_default: assert property (@(posedge i_sys_clk) disable iff (!i_rst_n)
        !st.pin_output_enable[6] |=> o_pad.oe[6] && o_pad.out[6] == $past(i_device_clock))
        else $error("clock not on clock pin");
    a_scan_keeps_pins: assert property (@(posedge i_sys_clk) disable iff (!i_rst_n)
        i_scan_mode |=> o_pad.oe[3:0] == 4'h0)
        else $error("scan pin driven in scan mode");
    a_output_value: assert property (@(posedge i_sys_clk) disable iff (!i_rst_n)
        (i_bus.wr && i_bus.addr == `RPG_ADDR_PIN_OUTPUT) ##1 !i_bus.wr
        |=> o_pad.out[5:0] == $past(i_bus.wdata[5:0], 2))
        else $error("output value not driven");
    a_input_read: assert property (@(posedge i_sys_clk) disable iff (!i_rst_n)
        (i_bus.rd && i_bus.addr == `RPG_ADDR_PIN_INPUT) |=> o_rdata == $past(pin_level))
        else $error("input level read wrong");
    a_fast_pad: assert property (@(posedge i_sys_clk) disable iff (!i_rst_n)
        (i_bus.wr && i_bus.addr == `RPG_ADDR_SIG_CONFIG)
        |=> o_fast_pad_switching == $past(i_bus.wdata[7]))
        else $error("pad speed not taken");
    a_sel_tristate: assert property (@(posedge i_sys_clk) disable iff (!i_rst_n)
        s_sel_write(4'h1) ##1 !i_bus.wr |=> !o_signal_output_oe)
        else $error("signal pin not tristate");
    a_sel_high: assert property (@(posedge i_sys_clk) disable iff (!i_rst_n)
        s_sel_write(4'h3) ##1 !i_bus.wr |=> o_signal_output_oe && o_signal_output_pin)
        else $error("signal pin not high");
    a_sel_tx_env: assert property (@(posedge i_sys_clk) disable iff (!i_rst_n)
        s_sel_write(4'h4) ##1 !i_bus.wr
        |=> o_signal_output_pin == $past(i_probe.tx_envelope))
        else $error("tx envelope not routed");
    a_sel_secure: assert property (@(posedge i_sys_clk) disable iff (!i_rst_n)
        s_sel_write(4'h6) ##1 !i_bus.wr
        |=> o_signal_output_pin == $past(i_probe.generic_secure_module_signal))
        else $error("secure signal not routed");
    a_sel_rx_act: assert property (@(posedge i_sys_clk) disable iff (!i_rst_n)
        s_sel_write(4'h8) ##1 !i_bus.wr |=> o_signal_output_pin == $past(i_probe.rx_active))
        else $error("rx active not routed");
    a_sel_rx_bit: assert property (@(posedge i_sys_clk) disable iff (!i_rst_n)
        s_sel_write(4'h9) ##1 !i_bus.wr |=> o_signal_output_pin == $past(i_probe.rx_bit))
        else $error("rx bit not routed");
    a_sel_reserved: assert property (@(posedge i_sys_clk) disable iff (!i_rst_n)
        s_sel_write(4'hC) ##1 !i_bus.wr |=> !o_signal_output_oe)
        else $error("reserved select drives pin");

    // ==========================================================
    // register read-back and hold checks
    sequence s_reg_write(logic [7:0] a);
        i_bus.wr && i_bus.addr == a;
    endsequence
    sequence s_reg_read(logic [7:0] a);
        i_bus.rd && i_bus.addr == a;
    endsequence
    sequence s_bus_quiet;
        !i_bus.wr;
    endsequence

    a_rdata_idle: assert property (@(posedge i_sys_clk) disable iff (!i_rst_n)
        !i_bus.rd
        |=> o_rdata == 8'h00)
        else $error("read data not cleared");

    a_enable_read: assert property (@(posedge i_sys_clk) disable iff (!i_rst_n)
        s_reg_read(`RPG_ADDR_PIN_ENABLE)
        |=> o_rdata == $past(st.pin_output_enable))
        else $error("enable read wrong");

    a_output_read: assert property (@(posedge i_sys_clk) disable iff (!i_rst_n)
        s_reg_read(`RPG_ADDR_PIN_OUTPUT)
        |=> o_rdata == $past(st.pin_output_value))
        else $error("output value read wrong");

    a_config_read: assert property (@(posedge i_sys_clk) disable iff (!i_rst_n)
        s_reg_read(`RPG_ADDR_SIG_CONFIG)
        |=> o_rdata[7] == $past(st.fast_pad_switching))
        else $error("pad speed read wrong");

    a_config_reserved: assert property (@(posedge i_sys_clk) disable iff (!i_rst_n)
        s_reg_read(`RPG_ADDR_SIG_CONFIG)
        |=> o_rdata[6:4] == 3'h0)
        else $error("reserved bits not zero");

    a_select_read: assert property (@(posedge i_sys_clk) disable iff (!i_rst_n)
        s_reg_read(`RPG_ADDR_SIG_CONFIG)
        |=> o_rdata[3:0] == $past(st.signal_output_source_select))
        else $error("select read wrong");

    a_unmapped_read: assert property (@(posedge i_sys_clk) disable iff (!i_rst_n)
        i_bus.rd && (i_bus.addr < `RPG_ADDR_PIN_ENABLE || i_bus.addr > `RPG_ADDR_SIG_CONFIG)
        |=> o_rdata == 8'h00)
        else $error("unmapped read not zero");

    a_input_ro: assert property (@(posedge i_sys_clk) disable iff (!i_rst_n)
        s_reg_write(`RPG_ADDR_PIN_INPUT)
        |=> $stable(st.pin_output_enable) && $stable(st.pin_output_value))
        else $error("input register took a write");

    a_enable_hold: assert property (@(posedge i_sys_clk) disable iff (!i_rst_n)
        !(i_bus.wr && i_bus.addr == `RPG_ADDR_PIN_ENABLE)
        |=> $stable(st.pin_output_enable))
        else $error("enable changed without write");

    a_select_hold: assert property (@(posedge i_sys_clk) disable iff (!i_rst_n)
        !(i_bus.wr && i_bus.addr == `RPG_ADDR_SIG_CONFIG)
        |=> $stable(st.signal_output_source_select))
        else $error("select changed without write");

    a_fast_pad_hold: assert property (@(posedge i_sys_clk) disable iff (!i_rst_n)
        !(i_bus.wr && i_bus.addr == `RPG_ADDR_SIG_CONFIG)
        |=> $stable(o_fast_pad_switching))
        else $error("pad speed changed without write");

    // ==========================================================
    // pad drive checks
    a_enable_low_bits: assert property (@(posedge i_sys_clk) disable iff (!i_rst_n)
        (i_bus.wr && i_bus.addr == `RPG_ADDR_PIN_ENABLE && !i_scan_mode) ##1 !i_scan_mode
        |=> o_pad.oe[5:0] == $past(i_bus.wdata[5:0], 2))
        else $error("low pin enables not applied");

    a_clock_gpio: assert property (@(posedge i_sys_clk) disable iff (!i_rst_n)
        st.pin_output_enable[6]
        |=> o_pad.oe[6] && o_pad.out[6] == $past(st.pin_output_value[6]))
        else $error("clock pin not general purpose");

    a_pad_out_follows: assert property (@(posedge i_sys_clk) disable iff (!i_rst_n)
        1'b1
        |=> o_pad.out[7] == $past(st.pin_output_value[7])
            && o_pad.out[5:0] == $past(st.pin_output_value[5:0]))
        else $error("pad value not from register");

    a_scan_free: assert property (@(posedge i_sys_clk) disable iff (!i_rst_n)
        !i_scan_mode
        |=> o_pad.oe[3:0] == $past(st.pin_output_enable[3:0]))
        else $error("scan pin enables ignored");

    // ==========================================================
    // signal-output select checks
    a_sel_tristate_a: assert property (@(posedge i_sys_clk) disable iff (!i_rst_n)
        s_sel_write(4'h0) ##1 s_bus_quiet
        |=> !o_signal_output_oe)
        else $error("signal pin not tristate");

    a_sel_low: assert property (@(posedge i_sys_clk) disable iff (!i_rst_n)
        s_sel_write(4'h2) ##1 s_bus_quiet
        |=> o_signal_output_oe && !o_signal_output_pin)
        else $error("signal pin not low");

    a_sel_tx_act: assert property (@(posedge i_sys_clk) disable iff (!i_rst_n)
        s_sel_write(4'h5) ##1 s_bus_quiet
        |=> o_signal_output_pin == $past(i_probe.tx_active))
        else $error("tx active not routed");

    a_sel_rx_env: assert property (@(posedge i_sys_clk) disable iff (!i_rst_n)
        s_sel_write(4'h7) ##1 s_bus_quiet
        |=> o_signal_output_pin == $past(i_probe.rx_envelope))
        else $error("rx envelope not routed");

    a_sel_res_a: assert property (@(posedge i_sys_clk) disable iff (!i_rst_n)
        s_sel_write(4'hA) ##1 s_bus_quiet
        |=> !o_signal_output_oe)
        else $error("reserved select drives pin");

    a_sel_res_b: assert property (@(posedge i_sys_clk) disable iff (!i_rst_n)
        s_sel_write(4'hB) ##1 s_bus_quiet
        |=> !o_signal_output_oe)
        else $error("reserved select drives pin");

    a_sel_res_d: assert property (@(posedge i_sys_clk) disable iff (!i_rst_n)
        s_sel_write(4'hD) ##1 s_bus_quiet
        |=> !o_signal_output_oe)
        else $error("reserved select drives pin");

    a_sel_res_e: assert property (@(posedge i_sys_clk) disable iff (!i_rst_n)
        s_sel_write(4'hE) ##1 s_bus_quiet
        |=> !o_signal_output_oe)
        else $error("reserved select drives pin");

    a_sel_res_f: assert property (@(posedge i_sys_clk) disable iff (!i_rst_n)
        s_sel_write(4'hF) ##1 s_bus_quiet
        |=> !o_signal_output_oe)
        else $error("reserved select drives pin");

    // drive only for the documented driving codes, whatever the history
    a_sig_oe_range: assert property (@(posedge i_sys_clk) disable iff (!i_rst_n)
        1'b1
        |=> o_signal_output_oe == ($past(st.signal_output_source_select) >= `RPG_SEL_LOW
            && $past(st.signal_output_source_select) <= `RPG_SEL_RX_BIT))
        else $error("signal pin drive wrong");
endmodule

// *** sim/rpg_pad_model.sv ***
// outside circuitry on the general purpose pins
`timescale 1ns/1ns
module rpg_pad_model (
    input wire rpg_pkg::rpg_pad_drive_t i_pad,
    input wire logic [7:0] i_ext_level,
    output logic [7:0] o_pad_level
);
    import rpg_pkg::*;
    // driven pads win over the outside level, so read-back sees the driven value
    assign o_pad_level = (i_pad.oe & i_pad.out) | (~i_pad.oe & i_ext_level);
endmodule

// *** sim/rpg_top_tb.sv ***
// self-checking bench for the pin configuration block
`timescale 1ns/1ns
module rpg_top_tb;
    import rpg_pkg::*;
    logic i_sys_clk;
    logic i_rst_n;
    rpg_bus_req_t bus;
    logic [7:0] rdata;
    logic [7:0] pad_level;
    logic [7:0] ext_level;
    rpg_pad_drive_t pad;
    logic scan_mode;
    logic dev_clk;
    rpg_probe_t probe;
    logic sig_pin;
    logic sig_oe;
    logic fast_pad;
    logic [7:0] v;
    int miscompares;
    int total_checks;

    rpg_top dut_u (.i_sys_clk(i_sys_clk), .i_rst_n(i_rst_n), .i_bus(bus), .o_rdata(rdata),
        .i_pad_in(pad_level), .o_pad(pad), .i_scan_mode(scan_mode),
        .i_device_clock(dev_clk), .i_probe(probe), .o_signal_output_pin(sig_pin),
        .o_signal_output_oe(sig_oe), .o_fast_pad_switching(fast_pad));
    rpg_pad_model pads_u (.i_pad(pad), .i_ext_level(ext_level), .o_pad_level(pad_level));

    // ========
    // bus and compare helpers
    task automatic chk(input string n, input logic [7:0] e, input logic [7:0] g);
        total_checks++;
        if (g !== e) begin
            miscompares++;
            $display("unexpected %s: expected %h seen %h", n, e, g);
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge i_sys_clk);
        bus <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
        @(posedge i_sys_clk);
        bus.wr <= 1'b0;
    endtask
    // read data stands only until the next edge, so take it at the falling edge
    task automatic rd(input logic [7:0] a, output logic [7:0] d);
        @(posedge i_sys_clk);
        bus <= '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
        @(posedge i_sys_clk);
        bus.rd <= 1'b0;
        @(negedge i_sys_clk);
        d = rdata;
    endtask
    task automatic wn(input int n);
        repeat (n) @(negedge i_sys_clk);
    endtask

    // ========
    // scenarios
    task automatic t_reset;
        chk("oe", 8'h40, pad.oe);
        chk("sig oe", 8'h00, {7'h00, sig_oe});
    endtask
    task automatic t_pins;
        for (int i = 0; i < 8; i++) begin
            wr(8'h44, 8'h01 << i);
            wn(2);
            chk("oe walk", (8'h01 << i) | 8'h40, pad.oe);
        end
        wr(8'h45, 8'hA5);
        wr(8'h44, 8'hFF);
        wn(2);
        chk("oe", 8'hFF, pad.oe);
        chk("out", 8'hA5, pad.out);
        wr(8'h44, 8'h00);
        for (int c = 1; c >= 0; c--) begin
            @(posedge i_sys_clk);
            dev_clk <= c[0];
            wn(3);
            chk("clock pin", {7'h00, c[0]}, {7'h00, pad.out[6]});
        end
    endtask
    task automatic t_scan;
        @(posedge i_sys_clk);
        scan_mode <= 1'b1;
        wr(8'h44, 8'hFF);
        wn(2);
        chk("scan oe", 8'hF0, pad.oe);
        rd(8'h44, v);
        chk("enable", 8'hFF, v);
        @(posedge i_sys_clk);
        scan_mode <= 1'b0;
    endtask
    task automatic t_input;
        wr(8'h44, 8'h00);
        ext_level <= 8'h3C;
        wn(6);
        rd(8'h46, v);
        chk("level", 8'h3C, v);
        wr(8'h45, 8'h5A);
        wr(8'h44, 8'hFF);
        wn(6);
        rd(8'h46, v);
        chk("readback", 8'h5A, v);
        wr(8'h46, 8'h00);
        wr(8'h10, 8'h00);
        rd(8'h46, v);
        chk("ro level", 8'h5A, v);
        rd(8'h44, v);
        chk("unmapped wr", 8'hFF, v);
        rd(8'h10, v);
        chk("unmapped rd", 8'h00, v);
    endtask
    task automatic t_signal_output_pin;
        logic eo;
        logic ep;
        for (int s = 0; s < 16; s++) begin
            wr(8'h47, {s[0], 3'b111, s[3:0]});
            rd(8'h47, v);
            chk("config", {s[0], 3'b000, s[3:0]}, v);
            chk("fast pad", {7'h00, s[0]}, {7'h00, fast_pad});
            eo = (s >= 2) && (s <= 9);
            for (int p = 0; p < 2; p++) begin
                @(posedge i_sys_clk);
                probe <= p[0] ? (6'h01 << (9 - s)) : ~(6'h01 << (9 - s));
                wn(3);
                ep = (s == 3) || ((s >= 4) && (s <= 9) && p[0]);
                chk("sig oe", {7'h00, eo}, {7'h00, sig_oe});
                if (eo) begin
                    chk("sig pin", {7'h00, ep}, {7'h00, sig_pin});
                end
            end
        end
    endtask

    // ========
    // run control
    task automatic report_and_stop;
        $display("checks %0d mismatches %0d", total_checks, miscompares);
        if (miscompares == 0 && total_checks > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask
    initial begin
        i_sys_clk = 1'b0;
        forever #20 i_sys_clk = ~i_sys_clk;
    end
    // whole run needs well under a thousand cycles
    initial begin
        #200000;
        miscompares++;
        report_and_stop;
    end
    initial begin
        i_rst_n = 1'b0;
        bus = '0;
        ext_level = 8'h00;
        scan_mode = 1'b0;
        dev_clk = 1'b0;
        probe = '0;
        miscompares = 0;
        total_checks = 0;
        repeat (4) @(posedge i_sys_clk);
        i_rst_n <= 1'b1;
        // the clock pin drive shows at the first edge that sees reset released
        wn(2);
        t_reset;
        t_pins;
        t_scan;
        t_input;
        t_signal_output_pin;
        report_and_stop;
    end
endmodule
